// [inc/adctrf_pkg.sv]
// adctrf_pkg: register map, field layout, reset values and shared types of the adc trigger/result block.
// assumes an AXI4-Lite slave with 32-bit data, one byte-wide register per aligned word.
package adctrf_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL0   = 8'h00; // channel_select, go, converter_on
   localparam logic [7:0] ADDR_CTRL1   = 8'h04; // result_format_select
   localparam logic [7:0] ADDR_TRIG    = 8'h08; // trigger_source_select
   localparam logic [7:0] ADDR_RES_HI  = 8'h0C;
   localparam logic [7:0] ADDR_RES_LO  = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h18;

   // field positions
   localparam int CTRL0_ON_BIT   = 0;
   localparam int CTRL0_GO_BIT   = 1;
   localparam int CTRL0_CHS_LSB  = 2;
   localparam int CTRL1_FMT_BIT  = 7;
   localparam int TRIG_SEL_LSB   = 4;
   localparam int IRQ_DONE_BIT   = 0;
   localparam int IRQ_T0_BIT     = 1;
   localparam int IRQ_T1_BIT     = 2;
   localparam int IRQ_WIDTH      = 3;

   // reset values
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [3:0] TRIG_RST  = 4'h0;

   // trigger select codes
   localparam logic [3:0] TSEL_NONE = 4'h0;
   localparam logic [3:0] TSEL_T0   = 4'h3;
   localparam logic [3:0] TSEL_T1   = 4'h4;
   localparam logic [3:0] TSEL_T2   = 4'h5;
   localparam logic [3:0] TSEL_C1   = 4'h6;
   localparam logic [3:0] TSEL_C2   = 4'h7;
   localparam logic [3:0] TSEL_LC1  = 4'h8;
   localparam logic [3:0] TSEL_LC2  = 4'h9;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // trigger sources travel together
   typedef struct packed {
      logic timer_zero_wrap;
      logic timer_one_wrap;
      logic timer_two_period_hit;
      logic comparator_one_synced;
      logic comparator_two_synced;
      logic logic_cell_one_output;
      logic logic_cell_two_output;
   } adctrf_src_t;

   // converter core handshake
   typedef struct packed {
      logic       done;
      logic [9:0] conversion_result;
   } adctrf_core_t;

endpackage : adctrf_pkg

// [hw/adctrf_trig_sel.sv]
// adctrf_trig_sel: source multiplexer and rising-edge detector for the auto-conversion trigger.
// assumes sources are synchronous to aclk.
module adctrf_trig_sel
   import adctrf_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // selection and sources
   input  wire logic [3:0]  trigger_source_select,
   input  wire adctrf_src_t src,
   // one-cycle edge pulse
   output logic             trig_pulse
);

   logic sel_lvl;
   logic prev_r;

   // reserved codes select nothing, so a held-low level never fires
   assign sel_lvl = (trigger_source_select == TSEL_T0)  ? src.timer_zero_wrap       :
                    (trigger_source_select == TSEL_T1)  ? src.timer_one_wrap        :
                    (trigger_source_select == TSEL_T2)  ? src.timer_two_period_hit  :
                    (trigger_source_select == TSEL_C1)  ? src.comparator_one_synced :
                    (trigger_source_select == TSEL_C2)  ? src.comparator_two_synced :
                    (trigger_source_select == TSEL_LC1) ? src.logic_cell_one_output :
                    (trigger_source_select == TSEL_LC2) ? src.logic_cell_two_output :
                    1'b0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= sel_lvl;
      end
   end

   // level high after a low sample; a steady high fires once only
   assign trig_pulse = sel_lvl & ~prev_r;

   AST_EDGE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
      trig_pulse |-> (sel_lvl && !$past(sel_lvl)))
      else $error("trigger pulse without rising edge");
   AST_RESERVED_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
      (trigger_source_select inside {4'h0, 4'h1, 4'h2, [4'hA:4'hF]}) |-> !sel_lvl)
      else $error("reserved select code drives a source");

endmodule : adctrf_trig_sel

// [hw/adctrf_fmt.sv]
// adctrf_fmt: places a 10-bit result into high/low bytes, left or right justified.
// assumes the caller loads both registers from these outputs in one cycle.
module adctrf_fmt
   import adctrf_pkg::*;
(
   // result and format
   input  wire logic [9:0] conversion_result,
   input  wire logic       result_format_select,
   // packed bytes
   output logic [7:0]      res_hi,
   output logic [7:0]      res_lo
);

   // unused six bits are forced to zero on load
   assign res_hi = result_format_select ? {6'h00, conversion_result[9:8]}
                                        : conversion_result[9:2];
   assign res_lo = result_format_select ? conversion_result[7:0]
                                        : {conversion_result[1:0], 6'h00};

endmodule : adctrf_fmt

// [hw/adctrf_top.sv]
// adctrf_top: control registers, auto-trigger, result formatting and interrupt for a 10-bit converter.
// assumes an AXI4-Lite master on aclk and an analog core that reports done with a result.
//
// What this block does
// - trigger select in bits 7:4; code 0, 1, 2, 10-15 select nothing
// - codes 3, 4, 5 select timer zero wrap, timer one wrap, timer two hit
// - codes 6, 7 comparators one/two; codes 8, 9 logic cells one/two
// - only a rising edge of the chosen source starts a conversion
// - a timer wrap used as trigger still sets its own interrupt flag
// - low four bits of trigger register read zero, writes ignored
// - left justified: high register holds result bits 9:2
// - left justified: low register holds result bits 1:0 in bits 7:6
// - right justified: high register holds result bits 9:8 in bits 1:0
// - right justified: low register holds result bits 7:0
// - result registers read/write, not reset; trigger select clears on reset
// - trigger edge sets go bit like a software write of one; here the edge sets go only while converter_on is high
// - the six unused result bits load as zero
// - on completion clear go, set done flag, load both result registers; here a go set in the same cycle keeps go high
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
module adctrf_top
   import adctrf_pkg::*;
(
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // axi4-lite write address
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   // axi4-lite write response
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   // trigger sources
   input  wire adctrf_src_t  src,
   // converter core
   input  wire adctrf_core_t core,
   output logic              core_start,
   output logic              converter_on,
   output logic [4:0]        channel_select,
   // interrupt
   output logic              irq
);

   logic [7:0]           ctrl0_r;
   logic [7:0]           ctrl0_nxt;
   logic                 fmt_r;
   logic [3:0]           tsel_r;
   logic [7:0]           res_hi_r;
   logic [7:0]           res_hi_nxt;
   logic [7:0]           res_lo_r;
   logic [7:0]           res_lo_nxt;
   logic [IRQ_WIDTH-1:0] ist_r;
   logic [IRQ_WIDTH-1:0] ist_nxt;
   logic [IRQ_WIDTH-1:0] imsk_r;
   logic                 go_r;
   logic                 go_nxt;
   logic                 start_r;
   logic                 irq_r;
   logic [7:0]           aw_addr_r;
   logic                 aw_held_r;
   logic [7:0]           w_data_r;
   logic                 w_strb_r;
   logic                 w_held_r;
   logic                 bvalid_r;
   logic [1:0]           bresp_r;
   logic                 rvalid_r;
   logic [31:0]          rdata_r;
   logic [1:0]           rresp_r;
   logic                 awready_r;
   logic                 wready_r;
   logic                 arready_r;

   // write decode
   logic       wr_fire;
   logic       wr_en;
   logic       wr_hit;
   logic       wr_ctrl0;
   logic       wr_ctrl1;
   logic       wr_trig;
   logic       wr_rhi;
   logic       wr_rlo;
   logic       wr_ist;
   logic       wr_imsk;
   logic       trig_pulse;
   logic       go_set;
   logic [7:0] fmt_hi;
   logic [7:0] fmt_lo;
   logic [IRQ_WIDTH-1:0] ev;
   logic       aw_take;
   logic       w_take;
   logic       ar_take;

   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
      addr_is = (a[7:2] == ref_a[7:2]);
   endfunction : addr_is

   assign wr_fire  = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_en    = wr_fire & w_strb_r;
   assign wr_ctrl0 = wr_en & addr_is(aw_addr_r, ADDR_CTRL0);
   assign wr_ctrl1 = wr_en & addr_is(aw_addr_r, ADDR_CTRL1);
   assign wr_trig  = wr_en & addr_is(aw_addr_r, ADDR_TRIG);
   assign wr_rhi   = wr_en & addr_is(aw_addr_r, ADDR_RES_HI);
   assign wr_rlo   = wr_en & addr_is(aw_addr_r, ADDR_RES_LO);
   assign wr_ist   = wr_en & addr_is(aw_addr_r, ADDR_IRQ_ST);
   assign wr_imsk  = wr_en & addr_is(aw_addr_r, ADDR_IRQ_MSK);
   assign wr_hit   = addr_is(aw_addr_r, ADDR_CTRL0) | addr_is(aw_addr_r, ADDR_CTRL1) |
                     addr_is(aw_addr_r, ADDR_TRIG) | addr_is(aw_addr_r, ADDR_RES_HI) |
                     addr_is(aw_addr_r, ADDR_RES_LO) | addr_is(aw_addr_r, ADDR_IRQ_ST) |
                     addr_is(aw_addr_r, ADDR_IRQ_MSK);

   // a channel is taken only while its ready flop stands high
   assign aw_take  = s_axi_awvalid & awready_r;
   assign w_take   = s_axi_wvalid & wready_r;
   assign ar_take  = s_axi_arvalid & arready_r;

   // the read mux packs the status into one byte; a wider layout needs a new map
   if (IRQ_WIDTH != 3 || TRIG_SEL_LSB != 4) begin : g_layout_check
      $error("status or trigger field layout does not fit the byte register");
   end

   // edges are found before the on gate; a rise while off is dropped, not replayed
   adctrf_trig_sel u_trig (
      .aclk                  (aclk),
      .aresetn               (aresetn),
      .trigger_source_select (tsel_r),
      .src                   (src),
      .trig_pulse            (trig_pulse)
   );

   adctrf_fmt u_fmt (
      .conversion_result    (core.conversion_result),
      .result_format_select (fmt_r),
      .res_hi               (fmt_hi),
      .res_lo               (fmt_lo)
   );

   // go set by edge behaves as software write of one; edge ignored while off
   assign go_set = (trig_pulse & ctrl0_r[CTRL0_ON_BIT]) |
                   (wr_ctrl0 & w_data_r[CTRL0_GO_BIT]);
   // start wins over a simultaneous done; go stays set, but no core_start pulse follows if go_r was already high
   assign go_nxt = go_set ? 1'b1 :
                   (core.done ? 1'b0 :
                   (wr_ctrl0 ? w_data_r[CTRL0_GO_BIT] : go_r));
   assign ctrl0_nxt = wr_ctrl0 ? {1'b0, w_data_r[6:0]} : ctrl0_r;

   // completion load outranks a same-cycle software write of the result
   assign res_hi_nxt = core.done ? fmt_hi : (wr_rhi ? w_data_r : res_hi_r);
   assign res_lo_nxt = core.done ? fmt_lo : (wr_rlo ? w_data_r : res_lo_r);

   // timer wraps flag whether or not they are the selected trigger
   assign ev = {src.timer_one_wrap, src.timer_zero_wrap, core.done};
   // set wins over write-one-to-clear
   assign ist_nxt = (ist_r & ~(wr_ist ? w_data_r[IRQ_WIDTH-1:0] : {IRQ_WIDTH{1'b0}})) | ev;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0_r <= CTRL0_RST;
         go_r    <= 1'b0;
         fmt_r   <= CTRL1_RST[CTRL1_FMT_BIT];
         tsel_r  <= TRIG_RST;
         ist_r   <= '0;
         imsk_r  <= '0;
         start_r <= 1'b0;
         irq_r   <= 1'b0;
      end else begin
         ctrl0_r <= ctrl0_nxt;
         go_r    <= go_nxt;
         start_r <= go_set & ~go_r;
         if (wr_ctrl1) begin
            fmt_r <= w_data_r[CTRL1_FMT_BIT];
         end
         if (wr_trig) begin
            tsel_r <= w_data_r[7:TRIG_SEL_LSB];
         end
         ist_r <= ist_nxt;
         if (wr_imsk) begin
            imsk_r <= w_data_r[IRQ_WIDTH-1:0];
         end
         // next-state terms keep irq in step with the status bit
         irq_r <= |(ist_nxt & (wr_imsk ? w_data_r[IRQ_WIDTH-1:0] : imsk_r));
      end
   end

   // result registers hold across reset; contents are undefined at power-up
   always_ff @(posedge aclk) begin
      res_hi_r <= res_hi_nxt;
      res_lo_r <= res_lo_nxt;
   end

   // write channels are taken independently, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_r <= 8'h00;
         aw_held_r <= 1'b0;
         w_data_r  <= 8'h00;
         w_strb_r  <= 1'b0;
         w_held_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
      end else begin
         if (aw_take) begin
            aw_addr_r <= s_axi_awaddr;
            aw_held_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (w_take) begin
            w_data_r <= s_axi_wdata[7:0];
            w_strb_r <= s_axi_wstrb[0];
            w_held_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // read mux
   // read data is sampled at the address hand-shake
   logic [7:0] rd_byte;
   logic       rd_hit;
   assign rd_hit  = addr_is(s_axi_araddr, ADDR_CTRL0) | addr_is(s_axi_araddr, ADDR_CTRL1) |
                    addr_is(s_axi_araddr, ADDR_TRIG) | addr_is(s_axi_araddr, ADDR_RES_HI) |
                    addr_is(s_axi_araddr, ADDR_RES_LO) | addr_is(s_axi_araddr, ADDR_IRQ_ST) |
                    addr_is(s_axi_araddr, ADDR_IRQ_MSK);
   assign rd_byte = addr_is(s_axi_araddr, ADDR_CTRL0)   ? {ctrl0_r[7:2], go_r, ctrl0_r[CTRL0_ON_BIT]} :
                    addr_is(s_axi_araddr, ADDR_CTRL1)   ? {fmt_r, 7'h00} :
                    addr_is(s_axi_araddr, ADDR_TRIG)    ? {tsel_r, 4'h0} :
                    addr_is(s_axi_araddr, ADDR_RES_HI)  ? res_hi_r :
                    addr_is(s_axi_araddr, ADDR_RES_LO)  ? res_lo_r :
                    addr_is(s_axi_araddr, ADDR_IRQ_ST)  ? {5'h00, ist_r} :
                    addr_is(s_axi_araddr, ADDR_IRQ_MSK) ? {5'h00, imsk_r} : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r  <= 1'b1;
         arready_r <= 1'b0;
         rdata_r   <= {24'h00_0000, rd_byte};
         rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign s_axi_awready  = awready_r;
   assign s_axi_wready   = wready_r;
   assign s_axi_bvalid   = bvalid_r;
   assign s_axi_bresp    = bresp_r;
   assign s_axi_arready  = arready_r;
   assign s_axi_rvalid   = rvalid_r;
   assign s_axi_rdata    = rdata_r;
   assign s_axi_rresp    = rresp_r;
   assign core_start     = start_r;
   assign converter_on   = ctrl0_r[CTRL0_ON_BIT];
   assign channel_select = ctrl0_r[6:CTRL0_CHS_LSB];
   assign irq            = irq_r;

   AST_TRIG_SETS_GO: assert property (@(posedge aclk) disable iff (!aresetn)
      (trig_pulse && ctrl0_r[CTRL0_ON_BIT]) |=> go_r)
      else $error("trigger edge did not set go");
   AST_DONE_CLEARS_GO: assert property (@(posedge aclk) disable iff (!aresetn)
      (core.done && !go_set) |=> !go_r)
      else $error("go not cleared on completion");
   AST_DONE_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      core.done |=> ist_r[IRQ_DONE_BIT])
      else $error("done flag not set");
   AST_T0_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      src.timer_zero_wrap |=> ist_r[IRQ_T0_BIT])
      else $error("timer zero flag not set");
   AST_T1_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      src.timer_one_wrap |=> ist_r[IRQ_T1_BIT])
      else $error("timer one flag not set");
   AST_LEFT_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
      (core.done && !fmt_r) |=> (res_hi_r == $past(core.conversion_result[9:2]) &&
                                 res_lo_r == {$past(core.conversion_result[1:0]), 6'h00}))
      else $error("left justified load wrong");
   AST_RIGHT_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
      (core.done && fmt_r) |=> (res_lo_r == $past(core.conversion_result[7:0]) &&
                                res_hi_r[7:2] == 6'h00))
      else $error("right justified load wrong");
   AST_TRIG_LOW_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && !rvalid_r && addr_is(s_axi_araddr, ADDR_TRIG)) |=> (rdata_r[3:0] == 4'h0))
      else $error("trigger low bits not zero");
   AST_STEADY_NO_START: assert property (@(posedge aclk) disable iff (!aresetn)
      (trig_pulse && !wr_ctrl0) |=> !trig_pulse)
      else $error("steady level fired twice");

   AST_EDGE_STARTS: assert property (@(posedge aclk) disable iff (!aresetn)
      (trig_pulse && ctrl0_r[CTRL0_ON_BIT] && !go_r) |=> core_start)
      else $error("trigger edge did not start the core");
   AST_NONE_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
      (tsel_r == TSEL_NONE) |-> !trig_pulse)
      else $error("no-trigger code produced an edge");
   AST_RST_TRIG: assert property (@(posedge aclk)
      !aresetn |=> (tsel_r == TRIG_RST && !go_r))
      else $error("reset did not clear trigger select and go");
   AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_r == |(ist_r & imsk_r))
      else $error("irq does not follow masked status");
   AST_B_STANDS: assert property (@(posedge aclk) disable iff (!aresetn)
      (bvalid_r && !s_axi_bready) |=> (bvalid_r && $stable(bresp_r)))
      else $error("write response dropped before bready");
   AST_R_STANDS: assert property (@(posedge aclk) disable iff (!aresetn)
      (rvalid_r && !s_axi_rready) |=> (rvalid_r && $stable(rdata_r)))
      else $error("read data dropped before rready");


   COV_TRIG: cover property (@(posedge aclk) disable iff (!aresetn) trig_pulse && ctrl0_r[CTRL0_ON_BIT]);
   COV_DONE_RIGHT: cover property (@(posedge aclk) disable iff (!aresetn) core.done && fmt_r);
   COV_DONE_LEFT: cover property (@(posedge aclk) disable iff (!aresetn) core.done && !fmt_r);
   COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_r));
   COV_TIMER_TRIG: cover property (@(posedge aclk) disable iff (!aresetn) trig_pulse && tsel_r == TSEL_T0);

endmodule : adctrf_top

// [verif/adctrf_core_model.sv]
// adctrf_core_model: behavioural stand-in for the analog converter core.
// assumes core_start is a one-cycle pulse on aclk; answers after lat+1 cycles.
module adctrf_core_model
   import adctrf_pkg::*;
(
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // control from the block
   input  wire logic         core_start,
   input  wire logic [9:0]   sample,
   input  wire logic [7:0]   lat,
   // answer to the block
   output adctrf_core_t      core
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy_r;
   logic [7:0] cnt_r;
   logic [9:0] last_r;

   // result bus shows the inverse of the last value outside done, never a stale copy
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_r                 <= 1'b0;
         cnt_r                  <= 8'h00;
         last_r                 <= 10'h000;
         core.done              <= 1'b0;
         core.conversion_result <= 10'h3FF;
      end else begin
         core.done              <= 1'b0;
         core.conversion_result <= ~last_r;
         if (core_start) begin
            busy_r <= 1'b1;
            cnt_r  <= lat;
         end else if (busy_r && cnt_r == 8'h00) begin
            busy_r                 <= 1'b0;
            core.done              <= 1'b1;
            core.conversion_result <= sample;
            last_r                 <= sample;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
endmodule : adctrf_core_model

// [verif/test_adc_trigger_and_result_format.sv]
// test_adc_trigger_and_result_format: self-checking bench for adctrf_top.
// assumes adctrf_pkg register map; drives AXI4-Lite and trigger sources directly.
module test_adc_trigger_and_result_format
   import adctrf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid, core_start, converter_on, irq;
   logic [1:0]  bresp, rresp, rsp;
   logic [4:0]  channel_select;
   logic [9:0]  sample;
   adctrf_src_t  src;
   adctrf_core_t core;
   int n_fail = 0;
   int check_count = 0;
   int n_start = 0;
   logic strb_lo = 1'b1;

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   always @(posedge aclk) if (core_start === 1'b1) n_start <= n_start + 1;

   adctrf_top i_adctrf_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .src(src), .core(core), .core_start(core_start), .converter_on(converter_on),
      .channel_select(channel_select), .irq(irq));

   adctrf_core_model i_adctrf_core_model (.aclk(aclk), .aresetn(aresetn), .core_start(core_start),
      .sample(sample), .lat(8'h03), .core(core));

   task check(input string name, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task finish_test;
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test

   task hang(input string name);
      n_fail++;
      $display("ERROR %s expected answer seen timeout", name);
      finish_test();
   endtask : hang

   task ticks(input int n);
      repeat (n) @(posedge aclk);
   endtask : ticks

   task axw(input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'h000000, d};
      wstrb   <= {3'h0, strb_lo};
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            rsp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (i == 100) hang("write response");
   endtask : axw

   task axr(input logic [7:0] a);
      int i;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rd = rdata;
            rsp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (i == 100) hang("read data");
   endtask : axr

   task wait_done;
      int i;
      for (i = 0; i < 50; i++) begin
         axr(ADDR_IRQ_ST);
         if (rd[IRQ_DONE_BIT] === 1'b1) break;
      end
      if (i == 50) hang("done flag");
   endtask : wait_done

   // one software-started conversion in the chosen format
   task conv(input logic [9:0] s, input logic right);
      sample <= s;
      axw(ADDR_CTRL1, {right, 7'h00});
      axw(ADDR_IRQ_ST, 8'h07);
      axw(ADDR_CTRL0, 8'h0D);
      ticks(20); // acquisition time after channel change
      axw(ADDR_CTRL0, 8'h0F);
      wait_done();
      axr(ADDR_CTRL0);
      check("go after done", rd, 32'h0000000D);
      axr(ADDR_RES_HI);
      check("result high", rd, right ? {30'h0, s[9:8]} : {24'h0, s[9:2]});
      axr(ADDR_RES_LO);
      check("result low", rd, right ? {24'h0, s[7:0]} : {24'h0, s[1:0], 6'h00});
   endtask : conv

   task t_reset;
      axr(ADDR_TRIG);
      check("trigger reset", rd, 32'h0);
      check("irq idle", irq, 1'b0);
   endtask : t_reset

   task t_trig_reg;
      axw(ADDR_TRIG, 8'hFF);
      axr(ADDR_TRIG);
      check("trigger low nibble", rd, 32'h000000F0);
   endtask : t_trig_reg

   task t_bus;
      axw(ADDR_RES_HI, 8'hA5);
      axr(ADDR_RES_HI);
      check("result high rw", rd, 32'h000000A5);
      strb_lo = 1'b0;
      axw(ADDR_RES_HI, 8'h3C);
      strb_lo = 1'b1;
      axr(ADDR_RES_HI);
      check("strobe off keeps", rd, 32'h000000A5);
      axw(8'h1C, 8'h55);
      check("unmapped write", rsp, RESP_SLVERR);
      axr(8'h1C);
      check("unmapped read resp", rsp, RESP_SLVERR);
      check("unmapped read data", rd, 32'h0);
      aresetn <= 1'b0;
      ticks(10);
      aresetn <= 1'b1;
      axr(ADDR_RES_HI);
      check("result kept over reset", rd, 32'h000000A5);
      axr(ADDR_TRIG);
      check("trigger cleared by reset", rd, 32'h0);
   endtask : t_bus

   task t_format;
      conv(10'h2D5, 1'b0);
      conv(10'h1AB, 1'b1);
      check("channel out", channel_select, 5'h03);
      check("converter on", converter_on, 1'b1);
   endtask : t_format

   // every select code: other sources must not start, the mapped one starts once on its edge
   task t_sources;
      int c;
      int n0;
      logic [6:0] m;
      for (c = 0; c < 16; c++) begin
         src <= '0;
         axw(ADDR_TRIG, {c[3:0], 4'h0});
         axw(ADDR_IRQ_ST, 8'h07);
         n0 = n_start;
         m = (c >= 3 && c <= 9) ? 7'h01 << (9 - c) : 7'h00;
         src <= adctrf_src_t'(~m);
         ticks(6);
         check("start on other source", n_start, n0);
         if (m != 7'h00) begin
            src <= adctrf_src_t'(7'h7F);
            ticks(6);
            check("start on edge", n_start, n0 + 1);
            ticks(8);
            check("level held", n_start, n0 + 1);
            wait_done();
            if (c == 3 || c == 4) check("timer flag", rd[c - 2], 1'b1);
         end
      end
      src <= '0;
   endtask : t_sources

   task t_irq;
      axw(ADDR_IRQ_MSK, 8'h01);
      conv(10'h3C1, 1'b0);
      ticks(2);
      check("irq on done", irq, 1'b1);
      axw(ADDR_IRQ_ST, 8'h01);
      ticks(2);
      check("irq after clear", irq, 1'b0);
      axw(ADDR_IRQ_MSK, 8'h00);
      conv(10'h00E, 1'b1);
      ticks(2);
      check("irq masked", irq, 1'b0);
   endtask : t_irq

   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      awaddr  = 8'h00;
      araddr  = 8'h00;
      wdata   = 32'h0;
      wstrb   = 4'h0;
      sample  = 10'h000;
      src     = '0;
      ticks(10);
      aresetn <= 1'b1;
      t_reset();
      t_trig_reg();
      t_bus();
      t_format();
      t_sources();
      t_irq();
      finish_test();
   end
endmodule : test_adc_trigger_and_result_format
